// [rtl/err_class_regs.vh]
`ifndef ERR_CLASS_REGS_VH
`define ERR_CLASS_REGS_VH
// register byte offsets
`define REG_CTRL 12'h000
`define REG_FAULT 12'h004
`define REG_ESR 12'h008
`define REG_QREAD 12'h00c
`define REG_QSTAT 12'h010
`define REG_LAST 12'h014
// control register fields
`define CTRL_CLR_BIT 0
`define CTRL_CLRESR_BIT 1
// fault register fields (one-shot: kind in [4:0], other bits ignored)
`define FAULT_KIND_W 5
// standard event status bit positions
`define ESR_CMD_BIT 5
`define ESR_EXE_BIT 4
`define ESR_DEV_BIT 3
`define ESR_QRY_BIT 2
// queue geometry
`define QDEPTH 30
`define QPTR_W 5
`define QCODE_W 17
// error codes as 17-bit signed values
`define CODE_NONE 17'h00000
`define CODE_CMD 17'h1ff9c
`define CODE_BADCHAR 17'h1ff9b
`define CODE_SYNTAX 17'h1ff9a
`define CODE_SEP 17'h1ff99
`define CODE_DTYPE 17'h1ff98
`define CODE_GET 17'h1ff97
`define CODE_PEXTRA 17'h1ff94
`define CODE_PMISS 17'h1ff93
`define CODE_LONG 17'h1ff90
`define CODE_UNDEF 17'h1ff8f
`define CODE_NUM 17'h1ff88
`define CODE_NUMCH 17'h1ff87
`define CODE_EXPO 17'h1ff85
`define CODE_DIGITS 17'h1ff84
`define CODE_NUMNA 17'h1ff80
`define CODE_SUFX 17'h1ff7d
`define CODE_SUFLONG 17'h1ff7a
`define CODE_SUFNA 17'h1ff76
`define CODE_CHDAT 17'h1ff73
`define CODE_CHNA 17'h1ff6c
`define CODE_EXEC 17'h1ff38
`define CODE_SETCONF 17'h1ff23
`define CODE_RANGE 17'h1ff22
`define CODE_DEVICE 17'h1fed4
`define CODE_SELFTEST 17'h1feb6
`define CODE_OVERFLOW 17'h1fea2
`define CODE_QUERY 17'h1fe70
`define CODE_UNTERM 17'h1fe6e
`define CODE_LOST 17'h1fe6d
// fault kinds presented by the parser/executor
`define K_NONE 5'h00
`define K_CMD 5'h01
`define K_BADCHAR 5'h02
`define K_SYNTAX 5'h03
`define K_SEP 5'h04
`define K_DTYPE 5'h05
`define K_GET 5'h06
`define K_PEXTRA 5'h07
`define K_PMISS 5'h08
`define K_LONG 5'h09
`define K_UNDEF 5'h0a
`define K_NUM 5'h0b
`define K_NUMCH 5'h0c
`define K_EXPO 5'h0d
`define K_DIGITS 5'h0e
`define K_NUMNA 5'h0f
`define K_SUFX 5'h10
`define K_SUFLONG 5'h11
`define K_SUFNA 5'h12
`define K_CHDAT 5'h13
`define K_CHNA 5'h14
`define K_EXEC 5'h15
`define K_SETCONF 5'h16
`define K_RANGE 5'h17
`define K_DEVICE 5'h18
`define K_SELFTEST 5'h19
`define K_QUERY 5'h1a
`define K_UNTERM 5'h1b
`define K_LOST 5'h1c
`define K_DEVPOS 5'h1d
// parser limits
`define NAME_MAX 8'd12
`define MANT_MAX 9'd255
`endif

// [rtl/error_fifo.v]
`timescale 1ns/1ps
`include "err_class_regs.vh"
module error_fifo (
  // clock and reset
  input wire mclk,
  input wire srst,
  // control
  input wire clear,
  input wire push,
  input wire [`QCODE_W-1:0] pushCode,
  input wire pop,
  // state
  output wire [`QCODE_W-1:0] headCode,
  output reg [`QPTR_W:0] count_q
);
  reg [`QCODE_W-1:0] mem [0:`QDEPTH-1];
  reg [`QPTR_W-1:0] rdPtr_q;
  reg [`QPTR_W-1:0] wrPtr_q;
  wire doPop = pop && (count_q != 6'd0);
  wire full = (count_q == 6'd30);
  wire almost = (count_q == 6'd29);
  wire [`QPTR_W-1:0] lastPtr = (wrPtr_q == 5'd0) ? 5'd29 : wrPtr_q - 5'd1;
  // head or the no-error code
  assign headCode = (count_q == 6'd0) ? `CODE_NONE : mem[rdPtr_q];

  // --------------------------------
  // storage and pointers
  // --------------------------------
  // the 30th slot is kept for the overflow marker, so a push onto 29 entries with no pop
  // writes the marker instead; pushes onto a full queue are dropped
  always @(posedge mclk) begin
    if (srst) begin
      rdPtr_q <= 5'd0;
      wrPtr_q <= 5'd0;
      count_q <= 6'd0;
    end else if (clear) begin
      // an error in the clearing cycle survives as the only entry
      if (push) begin
        mem[0] <= pushCode;
      end
      rdPtr_q <= 5'd0;
      wrPtr_q <= {4'h0, push};
      count_q <= {5'h00, push};
    end else begin
      if (push && !full && !(doPop && almost)) begin
        mem[wrPtr_q] <= (almost && !doPop) ? `CODE_OVERFLOW : pushCode;
        wrPtr_q <= (wrPtr_q == 5'd29) ? 5'd0 : wrPtr_q + 5'd1;
      end else if (push && full && !doPop) begin
        mem[lastPtr] <= `CODE_OVERFLOW;
      end else if (push && doPop && almost) begin
        mem[wrPtr_q] <= pushCode;
        wrPtr_q <= (wrPtr_q == 5'd29) ? 5'd0 : wrPtr_q + 5'd1;
      end
      if (doPop) begin
        rdPtr_q <= (rdPtr_q == 5'd29) ? 5'd0 : rdPtr_q + 5'd1;
      end
      if (push && !full && !doPop) begin
        count_q <= count_q + 6'd1;
      end else if (doPop && !(push && !full)) begin
        count_q <= count_q - 6'd1;
      end else if (doPop && push && full) begin
        count_q <= count_q - 6'd1;
      end
    end
  end
endmodule

// [rtl/command_error_classifier.v]
`timescale 1ns/1ps
`include "err_class_regs.vh"
// Operation
// - codes -100..-199 are command class, sets bit5
// - command fault raises no other class
// - execution faults -200..-299 set bit 4
// - out-of-range data or state blocks execution
// - range check after rounding; rounding never faults
// - execution fault raises no other class
// - device faults -300..-399 or positive, bit 3
// - self-test failure reports device-specific code
// - query faults -400..-499 set bit 2
// - read without output, or lost output
// - empty queue reads code zero
// - generic -100 when nothing more specific
// - -101 bad char, -102 syntax, -103 separator
// - -104 for wrong data type
// - -105 for trigger inside message
// - -108 too many, -109 too few parameters
// - -112 for names over twelve characters
// - -113 for undefined header
// - -121 bad radix char, else -120
// - -123 exponent overflow, -124 over 255 digits
// - -128 numeric where not accepted
// - -131 bad suffix, -134 long, -138 disallowed
// - -141 bad char data, -148 disallowed
// - 30-deep fifo, overflow marks last slot -350

module command_error_classifier (
  // clock and reset
  input wire mclk,
  input wire srst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // parser fault strobes, one cycle each
  input wire syntaxFault,
  input wire [4:0] syntaxKind,
  input wire [7:0] nameLen,
  input wire [7:0] suffixLen,
  input wire [8:0] mantDigits,
  // execution checks on rounded, evaluated values
  input wire execCheck,
  input wire signed [31:0] execValue,
  input wire signed [31:0] execMin,
  input wire signed [31:0] execMax,
  input wire execStateBlocked,
  // device-side events
  input wire selfTestFail,
  input wire devFault,
  input wire [14:0] devCode,
  // output queue events
  input wire readNoOutput,
  input wire outputLost,
  // message framing and bus trigger (pins)
  input wire inMessage,
  input wire triggerPin,
  // status
  output wire [7:0] eventStatus,
  output wire [`QCODE_W-1:0] headCode,
  output wire queueEmpty
);
  // --------------------------------
  // pin synchronisers
  // --------------------------------
  // two sync stages, then edge memory
  reg trigMeta_q;
  reg trigSync_q;
  reg trigPrev_q;
  reg msgMeta_q;
  reg msgSync_q;
  // two stages before anything looks at the trigger pin and frame level
  always @(posedge mclk) begin
    if (srst) begin
      trigMeta_q <= 1'b0;
      trigSync_q <= 1'b0;
      trigPrev_q <= 1'b0;
      msgMeta_q <= 1'b0;
      msgSync_q <= 1'b0;
    end else begin
      trigMeta_q <= triggerPin;
      trigSync_q <= trigMeta_q;
      trigPrev_q <= trigSync_q;
      msgMeta_q <= inMessage;
      msgSync_q <= msgMeta_q;
    end
  end

  // trigger rising while a message is open
  wire getInMsg = trigSync_q && !trigPrev_q && msgSync_q;

  // --------------------------------
  // command class code selection
  // --------------------------------
  // command class hit and its code
  reg [`QCODE_W-1:0] cmdCode;
  reg cmdHit;
  // length limits override a kind the parser reported loosely
  always @* begin
    // taken as a hit, dropped below when nothing fired
    cmdHit = 1'b1;
    cmdCode = `CODE_CMD;
    // a trigger in a message outranks the parser
    if (getInMsg) begin
      cmdCode = `CODE_GET;
    end else if (!syntaxFault) begin
      cmdHit = 1'b0;
    end else if (nameLen > `NAME_MAX) begin
      cmdCode = `CODE_LONG;
    end else if (suffixLen > `NAME_MAX) begin
      cmdCode = `CODE_SUFLONG;
    end else if (mantDigits > `MANT_MAX) begin
      cmdCode = `CODE_DIGITS;
    end else begin
      // otherwise the parser's kind picks the code
      case (syntaxKind)
        `K_BADCHAR: cmdCode = `CODE_BADCHAR;
        `K_SYNTAX: cmdCode = `CODE_SYNTAX;
        `K_SEP: cmdCode = `CODE_SEP;
        `K_DTYPE: cmdCode = `CODE_DTYPE;
        `K_GET: cmdCode = `CODE_GET;
        `K_PEXTRA: cmdCode = `CODE_PEXTRA;
        `K_PMISS: cmdCode = `CODE_PMISS;
        `K_LONG: cmdCode = `CODE_LONG;
        `K_UNDEF: cmdCode = `CODE_UNDEF;
        `K_NUM: cmdCode = `CODE_NUM;
        `K_NUMCH: cmdCode = `CODE_NUMCH;
        `K_EXPO: cmdCode = `CODE_EXPO;
        `K_DIGITS: cmdCode = `CODE_DIGITS;
        `K_NUMNA: cmdCode = `CODE_NUMNA;
        `K_SUFX: cmdCode = `CODE_SUFX;
        `K_SUFLONG: cmdCode = `CODE_SUFLONG;
        `K_SUFNA: cmdCode = `CODE_SUFNA;
        `K_CHDAT: cmdCode = `CODE_CHDAT;
        `K_CHNA: cmdCode = `CODE_CHNA;
        default: cmdCode = `CODE_CMD;
      endcase
    end
  end

  // --------------------------------
  // execution, device and query classes
  // --------------------------------
  // the value compared is already rounded and evaluated upstream, so a
  // rounding step alone can never reach here as a fault
  wire outOfRange = execCheck &&
    ((execValue < execMin) || (execValue > execMax));
  wire execHit = outOfRange || (execCheck && execStateBlocked);
  // a range fault reports before a blocked state
  wire [`QCODE_W-1:0] execCode = outOfRange ? `CODE_RANGE : `CODE_SETCONF;

  // device class: self-test beats a plain device fault
  wire devHit = selfTestFail || devFault;
  // positive device codes are 1..32767; zero would read as no error
  wire [`QCODE_W-1:0] devPos = {2'b00, devCode} | {16'h0000, (devCode == 15'h0000)};
  wire [`QCODE_W-1:0] devErrCode = selfTestFail ? `CODE_SELFTEST : devPos;

  // query class: lost output beats a read with none
  wire qryHit = readNoOutput || outputLost;
  wire [`QCODE_W-1:0] qryCode = outputLost ? `CODE_LOST : `CODE_UNTERM;

  // --------------------------------
  // exclusive class arbitration
  // --------------------------------
  // one fault source per cycle wins: command, then execution, device, query
  localparam [4:0] CL_NONE = 5'b00001;
  localparam [4:0] CL_CMD = 5'b00010;
  localparam [4:0] CL_EXE = 5'b00100;
  localparam [4:0] CL_DEV = 5'b01000;
  localparam [4:0] CL_QRY = 5'b10000;

  // winning class and its code
  reg [4:0] cls;
  reg [`QCODE_W-1:0] selCode;
  always @* begin
    // no class, no-error code by default
    cls = CL_NONE;
    selCode = `CODE_NONE;
    if (cmdHit) begin
      cls = CL_CMD;
      selCode = cmdCode;
    end else if (execHit) begin
      cls = CL_EXE;
      selCode = execCode;
    end else if (devHit) begin
      cls = CL_DEV;
      selCode = devErrCode;
    end else if (qryHit) begin
      cls = CL_QRY;
      selCode = qryCode;
    end
  end

  // --------------------------------
  // apb decode
  // --------------------------------
  // access phase strobes, one cycle each
  wire apbWr = psel && penable && pwrite;
  wire apbRd = psel && penable && !pwrite;
  wire wrCtrl = apbWr && (paddr == `REG_CTRL);
  wire wrFault = apbWr && (paddr == `REG_FAULT);
  wire rdQueue = apbRd && (paddr == `REG_QREAD);

  // decoded offsets; the rest answer with an error
  wire mapped = (paddr == `REG_CTRL) || (paddr == `REG_FAULT) || (paddr == `REG_ESR) ||
    (paddr == `REG_QREAD) || (paddr == `REG_QSTAT) || (paddr == `REG_LAST);

  // no wait states, so the master never stalls
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // software can inject a fault kind for bring-up through the fault register
  wire swFault = wrFault && (pwdata[4:0] != `K_NONE);
  // class and code of the injected kind
  reg [`QCODE_W-1:0] swCode;
  reg [4:0] swCls;
  always @* begin
    // nonzero kinds other than the execution, device and query ones, and K_DEVPOS as well, are generic commands
    swCls = CL_CMD;
    swCode = `CODE_CMD;
    case (pwdata[4:0])
      `K_EXEC: begin
        swCls = CL_EXE;
        swCode = `CODE_EXEC;
      end
      `K_RANGE: begin
        swCls = CL_EXE;
        swCode = `CODE_RANGE;
      end
      `K_SETCONF: begin
        swCls = CL_EXE;
        swCode = `CODE_SETCONF;
      end
      `K_DEVICE: begin
        swCls = CL_DEV;
        swCode = `CODE_DEVICE;
      end
      `K_SELFTEST: begin
        swCls = CL_DEV;
        swCode = `CODE_SELFTEST;
      end
      `K_QUERY: begin
        swCls = CL_QRY;
        swCode = `CODE_QUERY;
      end
      `K_UNTERM: begin
        swCls = CL_QRY;
        swCode = `CODE_UNTERM;
      end
      `K_LOST: begin
        swCls = CL_QRY;
        swCode = `CODE_LOST;
      end
      default: begin
        swCls = CL_CMD;
        swCode = `CODE_CMD;
      end
    endcase
  end

  // hardware faults take the queue slot when both arrive together
  wire hwAny = !cls[0];
  wire [4:0] finCls = hwAny ? cls : (swFault ? swCls : CL_NONE);
  wire [`QCODE_W-1:0] finCode = hwAny ? selCode : swCode;
  wire pushNow = hwAny || swFault;

  // --------------------------------
  // event status and last code
  // --------------------------------
  // sticky class bits and the last code queued
  reg [7:0] esr_q;
  reg [`QCODE_W-1:0] last_q;

  // bit0 clears queue and status, bit1 status only
  wire clrAll = wrCtrl && pwdata[`CTRL_CLR_BIT];
  wire clrEsr = wrCtrl && (pwdata[`CTRL_CLR_BIT] || pwdata[`CTRL_CLRESR_BIT]);
  // a set in the clear cycle survives
  always @(posedge mclk) begin
    if (srst) begin
      esr_q <= 8'h00;
      last_q <= `CODE_NONE;
    end else begin
      esr_q[`ESR_CMD_BIT] <= finCls[1] || (esr_q[`ESR_CMD_BIT] && !clrEsr);
      esr_q[`ESR_EXE_BIT] <= finCls[2] || (esr_q[`ESR_EXE_BIT] && !clrEsr);
      esr_q[`ESR_DEV_BIT] <= finCls[3] || (esr_q[`ESR_DEV_BIT] && !clrEsr);
      esr_q[`ESR_QRY_BIT] <= finCls[4] || (esr_q[`ESR_QRY_BIT] && !clrEsr);
      // reserved bits held low
      esr_q[7:6] <= 2'h0;
      esr_q[1:0] <= 2'h0;
      // last code follows every push, a clear keeps it
      if (pushNow) begin
        last_q <= finCode;
      end
    end
  end

  // status leaves straight from the flops
  assign eventStatus = esr_q;

  // --------------------------------
  // error queue
  // --------------------------------
  // entry count seen by the status read
  wire [`QPTR_W:0] qCount;
  // codes live here, the event status holds only classes
  error_fifo errQueue (
    .mclk(mclk),
    .srst(srst),
    .clear(clrAll),
    .push(pushNow),
    .pushCode(finCode),
    .pop(rdQueue),
    .headCode(headCode),
    .count_q(qCount)
  );

  // empty flag for the controller side
  assign queueEmpty = (qCount == 6'd0);

  // --------------------------------
  // read mux
  // --------------------------------
  // codes are sign-extended to the full word
  always @* begin
    prdata = 32'h00000000;
    // write-only and unmapped offsets read zero
    case (paddr)
      `REG_ESR: prdata = {24'h000000, esr_q};
      `REG_QREAD: prdata = {{15{headCode[16]}}, headCode};
      `REG_QSTAT: prdata = {26'h0000000, qCount};
      `REG_LAST: prdata = {{15{last_q[16]}}, last_q};
      default: prdata = 32'h00000000;
    endcase
  end
endmodule

// [bench/command_error_classifier_properties.sv]
`timescale 1ns/1ps
`include "err_class_regs.vh"
// ----------------------------------------
// port checker for the error classifier
// ----------------------------------------
module cec_checker (
  // clock and reset
  input wire mclk,
  input wire srst,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire pready,
  // fault sources
  input wire syntaxFault,
  input wire [4:0] syntaxKind,
  input wire execCheck,
  input wire signed [31:0] execValue,
  input wire signed [31:0] execMin,
  input wire signed [31:0] execMax,
  input wire execStateBlocked,
  input wire selfTestFail,
  input wire devFault,
  input wire readNoOutput,
  input wire outputLost,
  // status
  input wire [7:0] eventStatus,
  input wire [`QCODE_W-1:0] headCode,
  input wire queueEmpty
);
  // class causes; trigger pin ignored, its timing is internal
  wire cmdHit = syntaxFault && syntaxKind >= `K_CMD && syntaxKind <= `K_CHNA;
  wire outside = execValue < execMin || execValue > execMax;
  wire exeBad = execCheck && (outside || execStateBlocked);
  wire devHit = selfTestFail || devFault;
  wire qryHit = readNoOutput || outputLost;
  wire apbWr = psel && penable && pwrite;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);

  a_cmd_sets_bit: assert property (cmdHit |=> eventStatus[`ESR_CMD_BIT])
    else $error("command fault left its status bit clear");
  a_cmd_alone: assert property (cmdHit && eventStatus[4:2] == 3'h0 |=> eventStatus[4:2] == 3'h0)
    else $error("command fault raised another class");
  a_exe_sets_bit: assert property (exeBad && !cmdHit |=> eventStatus[`ESR_EXE_BIT])
    else $error("execution fault left its status bit clear");
  a_exe_alone: assert property (exeBad && !cmdHit && eventStatus[3:2] == 2'h0
    |=> eventStatus[3:2] == 2'h0)
    else $error("execution fault raised another class");
  a_round_silent: assert property (execCheck && !exeBad && !cmdHit && !devHit && !qryHit
    && !apbWr && eventStatus == 8'h00 |=> !eventStatus[`ESR_EXE_BIT])
    else $error("in-range value raised an execution fault");
  a_dev_sets_bit: assert property (devHit && !cmdHit && !exeBad |=> eventStatus[`ESR_DEV_BIT])
    else $error("device fault left its status bit clear");
  a_qry_sets_bit: assert property (qryHit && !cmdHit && !exeBad && !devHit
    |=> eventStatus[`ESR_QRY_BIT])
    else $error("query fault left its status bit clear");
  a_empty_code: assert property (queueEmpty |-> headCode == `CODE_NONE)
    else $error("empty queue shows a nonzero code");
  a_status_sticky: assert property (eventStatus[5] && !apbWr |=> eventStatus[5])
    else $error("command bit dropped without a clear");
  a_unused_low: assert property (eventStatus[7:6] == 2'h0 && eventStatus[1:0] == 2'h0)
    else $error("unused status bits set");

  // main scenarios reached
  cover property (cmdHit ##1 eventStatus[5]);
  cover property (exeBad ##1 eventStatus[4]);
  cover property (qryHit ##1 eventStatus[2]);
endmodule

bind command_error_classifier cec_checker i_cec_checker (.mclk, .srst, .psel, .penable,
  .pwrite, .pready, .syntaxFault, .syntaxKind, .execCheck, .execValue, .execMin, .execMax,
  .execStateBlocked, .selfTestFail, .devFault, .readNoOutput, .outputLost, .eventStatus,
  .headCode, .queueEmpty);

// [bench/program_source.sv]
`timescale 1ns/1ps
// ----------------------------------------
// controller side: parser, executor, bus events
// ----------------------------------------
module program_source (
  // clock
  input wire mclk,
  // parser faults
  output logic syntaxFault,
  output logic [4:0] syntaxKind,
  output logic [7:0] nameLen,
  output logic [7:0] suffixLen,
  output logic [8:0] mantDigits,
  // execution checks
  output logic execCheck,
  output logic signed [31:0] execValue,
  output logic signed [31:0] execMin,
  output logic signed [31:0] execMax,
  output logic execStateBlocked,
  // device and output queue events
  output logic selfTestFail,
  output logic devFault,
  output logic [14:0] devCode,
  output logic readNoOutput,
  output logic outputLost,
  // framing and trigger pins
  output logic inMessage,
  output logic triggerPin
);
  // quiet from time zero
  initial begin
    {syntaxFault, syntaxKind, nameLen, suffixLen, mantDigits} = '0;
    {execCheck, execValue, execMin, execMax, execStateBlocked} = '0;
    {selfTestFail, devFault, devCode, readNoOutput, outputLost, inMessage, triggerPin} = '0;
  end
  // one parser strobe, lengths sampled with it
  task automatic cmd(input logic [4:0] k, input logic [7:0] nl, input logic [7:0] sl,
      input logic [8:0] md);
    @(posedge mclk);
    {syntaxFault, syntaxKind, nameLen, suffixLen, mantDigits} <= {1'b1, k, nl, sl, md};
    @(posedge mclk);
    syntaxFault <= 1'b0;
  endtask
  // values come already rounded and evaluated
  task automatic exec(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi,
      input logic blk);
    @(posedge mclk);
    {execCheck, execValue, execMin, execMax, execStateBlocked} <= {1'b1, v, lo, hi, blk};
    @(posedge mclk);
    execCheck <= 1'b0;
  endtask
  // sel: self-test, device, no output, lost output
  task automatic ev(input logic [3:0] sel, input logic [14:0] code);
    @(posedge mclk);
    {selfTestFail, devFault, readNoOutput, outputLost, devCode} <= {sel, code};
    @(posedge mclk);
    {selfTestFail, devFault, readNoOutput, outputLost} <= 4'h0;
  endtask
  // bus trigger arriving while a message is open
  task automatic get_in_message();
    @(posedge mclk);
    inMessage <= 1'b1;
    repeat (4) @(posedge mclk);
    triggerPin <= 1'b1;
    repeat (4) @(posedge mclk);
    {inMessage, triggerPin} <= 2'h0;
  endtask
endmodule

// [bench/testbench.sv]
`timescale 1ns/1ps
`include "err_class_regs.vh"
module testbench;
  // ----------------------------------------
  // wiring
  // ----------------------------------------
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  wire pready, pslverr, syntaxFault, execCheck, execStateBlocked, selfTestFail, devFault;
  wire readNoOutput, outputLost, inMessage, triggerPin, queueEmpty;
  wire [31:0] prdata;
  wire [4:0] syntaxKind;
  wire [7:0] nameLen, suffixLen, eventStatus;
  wire [8:0] mantDigits;
  wire signed [31:0] execValue, execMin, execMax;
  wire [14:0] devCode;
  wire [`QCODE_W-1:0] headCode;
  int errors = 0;
  int n_checks = 0;
  logic [31:0] rd;
  logic err;

  command_error_classifier i_command_error_classifier (.mclk, .srst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .syntaxFault, .syntaxKind, .nameLen,
    .suffixLen, .mantDigits, .execCheck, .execValue, .execMin, .execMax, .execStateBlocked,
    .selfTestFail, .devFault, .devCode, .readNoOutput, .outputLost, .inMessage, .triggerPin,
    .eventStatus, .headCode, .queueEmpty);
  program_source i_program_source (.mclk, .syntaxFault, .syntaxKind, .nameLen, .suffixLen,
    .mantDigits, .execCheck, .execValue, .execMin, .execMax, .execStateBlocked, .selfTestFail,
    .devFault, .devCode, .readNoOutput, .outputLost, .inMessage, .triggerPin);

  // 100 ns clock
  initial forever #50 mclk = ~mclk;

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic results();
    $display("checks %0d, errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  // apb transfer; the bound on waiting guards against a stuck slave
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r);
    int i;
    @(posedge mclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge mclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    r = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
    if (i == 16) begin
      errors++;
      results();
    end
  endtask
  task automatic clr();
    apb(1'b1, `REG_CTRL, 32'h1, rd);
  endtask
  task automatic await_state(input logic [16:0] code, input logic [7:0] esr);
    repeat (2) @(posedge mclk);
    #1;
    check("head code", headCode, code);
    check("event status", eventStatus, esr);
  endtask
  task automatic cmd_case(input logic [4:0] k, input logic [7:0] nl, input logic [7:0] sl,
      input logic [8:0] md, input logic [16:0] code);
    clr();
    i_program_source.cmd(k, nl, sl, md);
    await_state(code, 8'h20);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // every command kind, then the length limits either side of their boundary
  task automatic s_cmd();
    logic [16:0] code [20] = '{`CODE_CMD, `CODE_BADCHAR, `CODE_SYNTAX, `CODE_SEP, `CODE_DTYPE,
      `CODE_GET, `CODE_PEXTRA, `CODE_PMISS, `CODE_LONG, `CODE_UNDEF, `CODE_NUM, `CODE_NUMCH,
      `CODE_EXPO, `CODE_DIGITS, `CODE_NUMNA, `CODE_SUFX, `CODE_SUFLONG, `CODE_SUFNA,
      `CODE_CHDAT, `CODE_CHNA};
    for (int k = 1; k <= 20; k++) begin
      cmd_case(5'(k), 8'h00, 8'h00, 9'h000, code[k-1]);
    end
    cmd_case(`K_UNDEF, 8'h0d, 8'h00, 9'h000, `CODE_LONG);
    cmd_case(`K_SUFX, 8'h00, 8'h0d, 9'h000, `CODE_SUFLONG);
    cmd_case(`K_NUM, 8'h00, 8'h00, 9'h100, `CODE_DIGITS);
    cmd_case(`K_UNDEF, 8'h0c, 8'h0c, 9'h0ff, `CODE_UNDEF);
  endtask
  // range edges, blocked state, and two faults in one cycle
  task automatic s_exec();
    clr();
    i_program_source.exec(32'h0b, 32'h00, 32'h0a, 1'b0);
    await_state(`CODE_RANGE, 8'h10);
    clr();
    i_program_source.exec(32'h0a, 32'h00, 32'h0a, 1'b0);
    await_state(`CODE_NONE, 8'h00);
    clr();
    i_program_source.exec(32'h05, 32'h00, 32'h0a, 1'b1);
    await_state(`CODE_SETCONF, 8'h10);
    clr();
    fork
      i_program_source.cmd(`K_CMD, 8'h00, 8'h00, 9'h000);
      i_program_source.exec(32'hffffffff, 32'h00, 32'h0a, 1'b0);
    join
    await_state(`CODE_CMD, 8'h20);
    clr();
    fork
      i_program_source.exec(32'hffffffff, 32'h00, 32'h0a, 1'b0);
      i_program_source.ev(4'h8, 15'h0000);
    join
    await_state(`CODE_RANGE, 8'h10);
    apb(1'b0, `REG_QSTAT, 32'h0, rd);
    check("queue count", rd, 32'h1);
  endtask
  // device codes, query codes, trigger inside a message
  task automatic s_events();
    clr();
    i_program_source.ev(4'h8, 15'h0000);
    await_state(`CODE_SELFTEST, 8'h08);
    clr();
    i_program_source.ev(4'h4, 15'h7fff);
    await_state(17'h07fff, 8'h08);
    for (int i = 0; i < 2; i++) begin
      clr();
      i_program_source.ev(i ? 4'h1 : 4'h2, 15'h0000);
      repeat (2) @(posedge mclk);
      #1;
      check("query code", headCode, i ? `CODE_LOST : `CODE_UNTERM);
      check("query bit", eventStatus, 8'h04);
    end
    clr();
    i_program_source.get_in_message();
    await_state(`CODE_GET, 8'h20);
  endtask
  // 31 faults into 30 slots, read back in order until empty
  task automatic s_queue();
    clr();
    i_program_source.cmd(`K_UNDEF, 8'h00, 8'h00, 9'h000);
    repeat (30) i_program_source.cmd(`K_CMD, 8'h00, 8'h00, 9'h000);
    apb(1'b0, `REG_QSTAT, 32'h0, rd);
    check("queue count", rd, 32'h1e);
    check("empty flag", {31'h0, queueEmpty}, 32'h0);
    for (int i = 0; i < 30; i++) begin
      apb(1'b0, `REG_QREAD, 32'h0, rd);
      check("queue entry", rd, {{15{1'b1}}, i == 0 ? `CODE_UNDEF : i == 29 ?
        `CODE_OVERFLOW : `CODE_CMD});
    end
    apb(1'b0, `REG_QREAD, 32'h0, rd);
    check("empty read", rd, 32'h0);
    check("empty flag", {31'h0, queueEmpty}, 32'h1);
  endtask
  // software injection, status-only clear, unmapped address
  task automatic s_regs();
    clr();
    apb(1'b1, `REG_FAULT, {27'h0, `K_DEVICE}, rd);
    await_state(`CODE_DEVICE, 8'h08);
    apb(1'b0, `REG_ESR, 32'h0, rd);
    check("status reg", rd, 32'h08);
    apb(1'b0, `REG_LAST, 32'h0, rd);
    check("last code", rd, {{15{1'b1}}, `CODE_DEVICE});
    apb(1'b1, `REG_CTRL, 32'h2, rd);
    apb(1'b0, `REG_QSTAT, 32'h0, rd);
    check("count kept", rd, 32'h1);
    check("status cleared", eventStatus, 8'h00);
    apb(1'b0, 12'h020, 32'h0, rd);
    check("unmapped error", {31'h0, err}, 32'h1);
    clr();
    apb(1'b1, `REG_FAULT, {27'h0, `K_LOST}, rd);
    await_state(`CODE_LOST, 8'h04);
    clr();
    apb(1'b1, `REG_FAULT, {27'h0, `K_EXEC}, rd);
    await_state(`CODE_EXEC, 8'h10);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    apb(1'b0, `REG_QREAD, 32'h0, rd);
    check("reset read", rd, 32'h0);
    s_cmd();
    s_exec();
    s_events();
    s_queue();
    s_regs();
    results();
  end
endmodule
